/* File: inc/fupc_pkg.sv */
package fupc_pkg;
  localparam logic [11:0] FUPC_ADDR_CMD = 12'h0ff8;
  localparam logic [11:0] FUPC_ADDR_PAGE = 12'h0ff9;
  localparam logic [7:0] FUPC_CMD_RST = 8'h00;
  localparam logic [7:0] FUPC_CMD_RESET = 8'h00;
  localparam logic [7:0] FUPC_CMD_UNLK1 = 8'h73;
  localparam logic [7:0] FUPC_CMD_UNLK2 = 8'h8c;
  localparam logic [7:0] FUPC_CMD_PERASE = 8'h95;
  localparam logic [7:0] FUPC_CMD_MERASE = 8'h63;
  localparam logic [7:0] FUPC_CMD_PROT = 8'h5e;
  localparam logic [7:0] FUPC_ERASED = 8'hff;
  localparam logic [7:0] FUPC_PROT_RST = 8'h00;
  localparam logic [6:0] FUPC_PAGE_RST = 7'h00;
  localparam logic [5:0] FUPC_ST_LOCKED = 6'h00;
  localparam logic [5:0] FUPC_ST_UNLK1 = 6'h01;
  localparam logic [5:0] FUPC_ST_UNLK2 = 6'h02;
  localparam logic [5:0] FUPC_ST_OPEN = 6'h03;
  localparam logic [5:0] FUPC_ST_PROT = 6'h04;
  localparam logic [5:0] FUPC_ST_PROG = 6'h08;
  localparam logic [5:0] FUPC_ST_PERASE = 6'h10;
  localparam logic [5:0] FUPC_ST_MERASE = 6'h20;
  localparam int FUPC_PAGE_MSB = 15;
  localparam int FUPC_PAGE_LSB = 9;
  localparam int FUPC_SECT_LSB = 13;
  // operation times in ns, cycles derived at 100 MHz
  localparam int FUPC_CLK_NS = 10;
  localparam int FUPC_PROG_NS = 400;
  localparam int FUPC_PROG_CYC = (FUPC_PROG_NS + FUPC_CLK_NS - 1) / FUPC_CLK_NS;
  localparam logic [9:0] FUPC_PROG_CNT = 10'(FUPC_PROG_CYC);
  localparam int FUPC_PAGE_BYTES = 512;
  localparam int FUPC_MEM_BYTES = 65536;

  typedef struct packed {
    logic we;
    logic re;
    logic [11:0] addr;
    logic [7:0] wdata;
  } fupc_reg_req_s;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fupc_mem_req_s;
endpackage

/* File: logic/fupc_ctrl.sv */
`timescale 1ns/100ps
// flash unlock and protection controller with program and erase sequencing
module fupc_ctrl
  import fupc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire fupc_pkg::fupc_reg_req_s i_reg,
  input wire logic i_debug,
  input wire logic i_wprot_opt,
  input wire fupc_pkg::fupc_mem_req_s i_mem,
  input wire logic [15:0] i_raddr,
  output logic [7:0] o_reg_rdata,
  output logic [7:0] o_mem_rdata,
  output logic o_stall,
  output logic [5:0] o_state,
  output logic [7:0] o_sect_prot
);
  import fupc_pkg::*;

  typedef enum {
    S_LOCKED, S_UNLK1, S_UNLK2, S_WAIT_PAGE, S_OPEN, S_PROT,
    S_PROG, S_PERASE, S_MERASE
  } fupc_state_e;

  fupc_state_e state_ff, nxt_state;
  logic [6:0] page_ff, nxt_page;
  logic [7:0] prot_ff, nxt_prot;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [5:0] code;
  logic cmd_wr, page_wr, page_prot, mem_ok;
  logic arr_prog, arr_erase;
  logic [15:0] arr_addr;
  logic [7:0] arr_wdata;

  assign cmd_wr = i_reg.we && (i_reg.addr == FUPC_ADDR_CMD);
  assign page_wr = i_reg.we && (i_reg.addr == FUPC_ADDR_PAGE);
  // sector of the open page is its top three page bits
  assign page_prot = prot_ff[page_ff[6:4]] && !i_debug;

  // a processor byte write is accepted only inside the open page
  always_comb
  begin
    mem_ok = i_mem.we && (state_ff == S_OPEN);
    if (!i_debug)
    begin
      if (i_mem.addr[FUPC_PAGE_MSB:FUPC_PAGE_LSB] != page_ff)
        mem_ok = 1'b0;
      if (i_wprot_opt || page_prot)
        mem_ok = 1'b0;
    end
    else if (prot_ff[i_mem.addr[15:13]] && 1'b0)
      mem_ok = 1'b0;
  end

  // sequencer: command and page writes step the lock state
  always_comb
  begin
    nxt_state = state_ff;
    nxt_page = page_ff;
    nxt_prot = prot_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      S_LOCKED, S_UNLK1, S_UNLK2, S_WAIT_PAGE, S_OPEN, S_PROT:
      begin
        if (cmd_wr)
        begin
          nxt_state = S_LOCKED;
          case (i_reg.wdata)
            FUPC_CMD_PROT:
              nxt_state = S_PROT;
            FUPC_CMD_UNLK1:
              if (state_ff == S_LOCKED)
                nxt_state = S_UNLK1;
            FUPC_CMD_UNLK2:
              if (state_ff == S_UNLK1)
                nxt_state = i_debug ? S_OPEN : S_WAIT_PAGE;
            FUPC_CMD_PERASE:
              if (state_ff == S_OPEN && !(i_wprot_opt && !i_debug)
                  && !page_prot)
              begin
                nxt_state = S_PERASE;
                nxt_cnt = 16'(FUPC_PAGE_BYTES - 1);
              end
            FUPC_CMD_MERASE:
              if (state_ff == S_OPEN && i_debug)
              begin
                nxt_state = S_MERASE;
                nxt_cnt = 16'(FUPC_MEM_BYTES - 1);
              end
            default:
              nxt_state = S_LOCKED;
          endcase
        end
        else if (page_wr)
        begin
          if (state_ff == S_PROT)
            nxt_prot = i_debug ? i_reg.wdata
                               : (prot_ff | i_reg.wdata);
          else if (state_ff == S_LOCKED)
            nxt_page = i_reg.wdata[6:0];
          else if (state_ff == S_WAIT_PAGE
                   && i_reg.wdata[6:0] == page_ff)
            nxt_state = S_OPEN;
          else if (state_ff == S_OPEN && i_debug)
            nxt_page = i_reg.wdata[6:0];
          else
            nxt_state = S_LOCKED;
        end
        else if (mem_ok)
        begin
          nxt_state = S_PROG;
          nxt_cnt = 16'(FUPC_PROG_CNT);
        end
      end
      S_PROG:
      begin
        nxt_cnt = cnt_ff - 16'h0001;
        if (cnt_ff == 16'h0000)
          nxt_state = S_OPEN; // stays in program until 00h, then back to open
      end
      S_PERASE, S_MERASE:
      begin
        nxt_cnt = cnt_ff - 16'h0001;
        if (cnt_ff == 16'h0000)
          nxt_state = S_LOCKED;
      end
      default:
        nxt_state = S_LOCKED;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_ff <= S_LOCKED;
      page_ff <= FUPC_PAGE_RST;
      prot_ff <= FUPC_PROT_RST;
      cnt_ff <= 16'h0000;
    end
    else
    begin
      state_ff <= nxt_state;
      page_ff <= nxt_page;
      prot_ff <= nxt_prot;
      cnt_ff <= nxt_cnt;
    end
  end

  // held program address and data captured at acceptance
  logic [15:0] paddr_ff, nxt_paddr;
  logic [7:0] pdata_ff, nxt_pdata;

  always_comb
  begin
    nxt_paddr = paddr_ff;
    nxt_pdata = pdata_ff;
    if (mem_ok && state_ff == S_OPEN && !cmd_wr && !page_wr)
    begin
      nxt_paddr = i_mem.addr;
      nxt_pdata = i_mem.wdata;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      paddr_ff <= 16'h0000;
      pdata_ff <= 8'h00;
    end
    else
    begin
      paddr_ff <= nxt_paddr;
      pdata_ff <= nxt_pdata;
    end
  end

  // array strobes: program once at the end, erase walks one byte a cycle
  always_comb
  begin
    arr_prog = (state_ff == S_PROG) && (cnt_ff == 16'h0000);
    arr_erase = (state_ff == S_PERASE) || (state_ff == S_MERASE);
    arr_wdata = pdata_ff;
    if (state_ff == S_PERASE)
      arr_addr = {page_ff, cnt_ff[8:0]};
    else if (state_ff == S_MERASE)
      arr_addr = cnt_ff;
    else
      arr_addr = paddr_ff;
  end

  fupc_flash_array u_array (
    .i_clk(i_clk),
    .i_prog(arr_prog),
    .i_erase(arr_erase),
    .i_addr(arr_addr),
    .i_wdata(arr_wdata),
    .i_raddr(i_raddr),
    .o_rdata(o_mem_rdata)
  );

  // state code shown at the command address
  always_comb
  begin
    case (state_ff)
      S_LOCKED: code = FUPC_ST_LOCKED;
      S_UNLK1: code = FUPC_ST_UNLK1;
      S_UNLK2, S_WAIT_PAGE: code = FUPC_ST_UNLK2;
      S_OPEN: code = FUPC_ST_OPEN;
      S_PROT: code = FUPC_ST_PROT;
      S_PROG: code = FUPC_ST_PROG;
      S_PERASE: code = FUPC_ST_PERASE;
      S_MERASE: code = FUPC_ST_MERASE;
      default: code = FUPC_ST_LOCKED;
    endcase
  end

  // register read mux, registered; command address reads back the state code
  always_comb
  begin
    nxt_rdata = 8'h00;
    if (i_reg.re && i_reg.addr == FUPC_ADDR_CMD)
      nxt_rdata = {2'b00, code};
    else if (i_reg.re && i_reg.addr == FUPC_ADDR_PAGE)
      nxt_rdata = (state_ff == S_PROT) ? prot_ff
                                        : {1'b0, page_ff};
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= nxt_rdata;
  end

  assign o_reg_rdata = rdata_ff;
  // stall covers program and erase; interrupts wait with the core
  assign o_stall = (state_ff == S_PROG) || arr_erase;
  assign o_state = code;
  assign o_sect_prot = prot_ff;

  chk_reset_locks: assert property (@(posedge i_clk)
    i_rst |=> (o_state == FUPC_ST_LOCKED && o_sect_prot == 8'h00))
    else $error("not locked after reset");

  chk_prot_set_only: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_debug |=> ((o_sect_prot & $past(o_sect_prot)) == $past(o_sect_prot)))
    else $error("protection bit cleared by processor");

  chk_no_user_mass: assert property (@(posedge i_clk) disable iff (i_rst)
    (!i_debug && state_ff != S_MERASE) |=> state_ff != S_MERASE)
    else $error("processor started whole-array erase");

  chk_bad_cmd_locks: assert property (@(posedge i_clk) disable iff (i_rst)
    (cmd_wr && i_reg.wdata == 8'h11 && state_ff == S_OPEN)
      |=> o_state == FUPC_ST_LOCKED)
    else $error("bad command did not lock");

  chk_wprot_blocks: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_wprot_opt && !i_debug) |-> !mem_ok)
    else $error("program accepted under write-protect");

  chk_page_bound: assert property (@(posedge i_clk) disable iff (i_rst)
    (mem_ok && !i_debug) |->
      i_mem.addr[FUPC_PAGE_MSB:FUPC_PAGE_LSB] == page_ff)
    else $error("program outside open page");

  chk_erase_relock: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_ff == S_PERASE && cnt_ff == 16'h0000)
      |=> (o_state == FUPC_ST_LOCKED && !o_stall))
    else $error("no relock after page erase");

  chk_erase_stall: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(state_ff == S_PERASE) |-> o_stall [*8])
    else $error("stall dropped during erase");

  chk_prog_length: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(state_ff == S_PROG) |-> ##41 (state_ff == S_OPEN))
    else $error("program length wrong");
endmodule

/* File: logic/fupc_flash_array.sv */
`timescale 1ns/100ps
// flash cell array: program ands data in, erase sets bytes back to ones
module fupc_flash_array
  import fupc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_prog,
  input wire logic i_erase,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [15:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [FUPC_MEM_BYTES];
  logic [7:0] rdata_ff;

  // no reset on the array; content survives like real flash
  always_ff @(posedge i_clk)
  begin
    if (i_erase)
      mem[i_addr] <= FUPC_ERASED;
    else if (i_prog)
      mem[i_addr] <= mem[i_addr] & i_wdata;
    rdata_ff <= mem[i_raddr];
  end

  assign o_rdata = rdata_ff;
endmodule

/* File: testbench/fupc_cpu_model.sv */
`timescale 1ns/100ps
// processor and debugger side: register strobes, byte writes, flash reads
module fupc_cpu_model
  import fupc_pkg::*;
(
  input wire logic i_clk,
  input wire logic [7:0] i_mem_rdata,
  input wire logic [7:0] i_reg_rdata,
  output fupc_pkg::fupc_reg_req_s o_reg,
  output fupc_pkg::fupc_mem_req_s o_mem,
  output logic [15:0] o_raddr
);
  initial
  begin
    o_reg = '0;
    o_mem = '0;
    o_raddr = 16'h0000;
  end
  // one-cycle register strobe; the caller waits for stall low first
  task automatic reg_acc(input logic we, input logic [11:0] a,
                         input logic [7:0] d, output logic [7:0] q);
    @(posedge i_clk);
    o_reg <= '{we: we, re: !we, addr: a, wdata: d};
    @(posedge i_clk);
    o_reg <= '0;
    #1 q = i_reg_rdata;
  endtask
  // byte write; the core idles while programming, so no overlap
  task automatic mem_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_mem <= '{we: 1'b1, addr: a, wdata: d};
    @(posedge i_clk);
    o_mem <= '0;
  endtask
  task automatic mem_rd(input logic [15:0] a, output logic [7:0] q);
    @(posedge i_clk);
    o_raddr <= a;
    repeat (2) @(posedge i_clk);
    #1 q = i_mem_rdata;
  endtask
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import fupc_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic dbg = 1'b0;
  logic wp = 1'b0;
  fupc_reg_req_s reg_req;
  fupc_mem_req_s mem_req;
  logic [15:0] raddr;
  logic [7:0] reg_rdata, mem_rdata, prot, q;
  logic stall;
  logic [5:0] state;
  int fail_count = 0;
  int tests_run = 0;
  int n;
  // unlock walk: address, data (page slot ignored), state after the write
  localparam logic [25:0] ROWS [5] = '{
    {FUPC_ADDR_CMD, 8'h00, FUPC_ST_LOCKED},
    {FUPC_ADDR_PAGE, 8'h00, FUPC_ST_LOCKED},
    {FUPC_ADDR_CMD, 8'h73, FUPC_ST_UNLK1},
    {FUPC_ADDR_CMD, 8'h8c, FUPC_ST_UNLK2},
    {FUPC_ADDR_PAGE, 8'h00, FUPC_ST_OPEN}};
  initial
  begin
    forever #5 i_clk = ~i_clk;
  end
  fupc_ctrl i_fupc_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_reg(reg_req),
    .i_debug(dbg), .i_wprot_opt(wp), .i_mem(mem_req), .i_raddr(raddr),
    .o_reg_rdata(reg_rdata), .o_mem_rdata(mem_rdata), .o_stall(stall),
    .o_state(state), .o_sect_prot(prot));
  fupc_cpu_model i_fupc_cpu_model (.i_clk(i_clk), .i_mem_rdata(mem_rdata),
    .i_reg_rdata(reg_rdata), .o_reg(reg_req), .o_mem(mem_req),
    .o_raddr(raddr));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    i_fupc_cpu_model.reg_acc(1'b1, a, d, q);
  endtask
  // counts stall cycles; a hang past the bound ends the run
  task automatic op_len();
    n = 0;
    while (stall === 1'b1 && n < 70000)
    begin
      @(posedge i_clk);
      #1 n++;
    end
    if (n >= 70000)
    begin
      fail_count++;
      stop_test();
    end
  endtask
  task automatic unlock(input logic [7:0] pg);
    foreach (ROWS[i])
    begin
      wr(ROWS[i][25:14],
         ROWS[i][25:14] == FUPC_ADDR_PAGE ? pg : ROWS[i][13:6]);
      chk(state, ROWS[i][5:0]);
    end
  endtask
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    #1 chk({state, 2'b00, prot}, 16'h0000);
    chk(stall, 0);
    unlock(8'h21);
    wr(FUPC_ADDR_CMD, 8'h95);
    op_len();
    chk(n >= FUPC_PAGE_BYTES && n <= FUPC_PAGE_BYTES + 2, 1);
    chk(state, FUPC_ST_LOCKED);
    i_fupc_cpu_model.mem_rd(16'h43ff, q);
    chk(q, FUPC_ERASED);
    $display("page erase test done");
    unlock(8'h21);
    i_fupc_cpu_model.mem_wr(16'h4204, 8'h5a);
    #1 op_len();
    chk(n >= FUPC_PROG_CYC && n <= FUPC_PROG_CYC + 1, 1);
    chk(state, FUPC_ST_OPEN);
    i_fupc_cpu_model.mem_wr(16'h4204, 8'hf0);
    #1 op_len();
    i_fupc_cpu_model.mem_rd(16'h4204, q);
    chk(q, 8'h50);
    i_fupc_cpu_model.mem_wr(16'h4600, 8'h00);
    #1 chk(stall, 0);
    wr(FUPC_ADDR_CMD, 8'h00);
    i_fupc_cpu_model.reg_acc(1'b0, FUPC_ADDR_CMD, 8'h00, q);
    chk(q, FUPC_ST_LOCKED);
    $display("program test done");
    for (int i = 0; i < 3; i++)
      wr(ROWS[i][25:14], ROWS[i][13:6]);
    wr(FUPC_ADDR_CMD, 8'h95);
    chk({stall, state}, FUPC_ST_LOCKED);
    unlock(8'h21);
    wr(FUPC_ADDR_CMD, FUPC_CMD_MERASE);
    chk({stall, state}, FUPC_ST_LOCKED);
    wr(FUPC_ADDR_CMD, FUPC_CMD_PROT);
    chk(state, FUPC_ST_PROT);
    wr(FUPC_ADDR_PAGE, 8'h04);
    wr(FUPC_ADDR_PAGE, 8'h00);
    chk(prot, 8'h04);
    i_fupc_cpu_model.reg_acc(1'b0, FUPC_ADDR_PAGE, 8'h00, q);
    chk(q, 8'h04);
    wr(FUPC_ADDR_CMD, 8'h00);
    wr(FUPC_ADDR_PAGE, 8'h0f);
    chk({state, 2'b00, prot}, 16'h0004);
    unlock(8'h21);
    i_fupc_cpu_model.mem_wr(16'h4210, 8'h00);
    #1 chk(stall, 0);
    wr(FUPC_ADDR_CMD, 8'h95);
    chk(stall, 0);
    wp <= 1'b1;
    unlock(8'h10);
    i_fupc_cpu_model.mem_wr(16'h2000, 8'h00);
    #1 chk(stall, 0);
    $display("protection test done");
    // write-protect stays on: the debugger must ignore it
    dbg <= 1'b1;
    for (int i = 0; i < 4; i++)
      wr(ROWS[i][25:14],
         ROWS[i][25:14] == FUPC_ADDR_PAGE ? 8'h21 : ROWS[i][13:6]);
    chk(state, FUPC_ST_OPEN);
    i_fupc_cpu_model.mem_wr(16'h6000, 8'h00);
    #1 chk(stall, 1);
    op_len();
    wr(FUPC_ADDR_CMD, FUPC_CMD_PROT);
    wr(FUPC_ADDR_PAGE, 8'h00);
    chk(prot, 8'h00);
    for (int i = 0; i < 4; i++)
      wr(ROWS[i][25:14], ROWS[i][13:6]);
    wr(FUPC_ADDR_CMD, FUPC_CMD_MERASE);
    chk({stall, state}, {1'b1, FUPC_ST_MERASE});
    i_rst <= 1'b1;
    @(posedge i_clk);
    i_rst <= 1'b0;
    #1 chk({stall, state}, FUPC_ST_LOCKED);
    $display("debug test done");
    stop_test();
  end
endmodule
